//--- hdl/ptsr_fifo.sv
// Parameterised queue of DEPTH entries with valid and ready on both sides.
`timescale 1ns/100ps
module ptsr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Filling side.
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  // Draining side.
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cntD;
  logic          inReady_q;
  logic          outValid_q;
  wire           push = inValid && inReady_q;
  wire           pop  = outValid_q && outReady;

  assign cntD     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign inReady  = inReady_q;
  assign outValid = outValid_q;
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      cnt_q      <= '0;
      inReady_q  <= 1'b1;
      outValid_q <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
      end
      cnt_q      <= cntD;
      inReady_q  <= (cntD != FULL);
      outValid_q <= (cntD != '0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule

//--- hdl/ptsr_pkg.sv
// Constants and field layout shared by the timestamp readout block.
package ptsr_pkg;
  // Register addresses on the management read port.
  localparam logic [4:0] PTSR_TX_ADDR   = 5'h1C;
  localparam logic [4:0] PTSR_RX_ADDR   = 5'h1D;
  localparam logic [4:0] PTSR_ESTS_ADDR = 5'h1E;
  localparam logic [4:0] PTSR_EDAT_ADDR = 5'h1F;
  localparam logic [15:0] PTSR_RESET_WORD = 16'h0000;

  // Timestamp geometry.
  localparam int PTSR_NS_W    = 30;
  localparam int PTSR_SEC_W   = 32;
  localparam int PTSR_STAMP_W = PTSR_NS_W + PTSR_SEC_W;
  localparam int PTSR_RXID_W  = 32;
  localparam int PTSR_EXT_W   = 16;
  localparam int PTSR_ESTS_W  = 11;
  localparam int PTSR_UNITS   = 8;
  localparam int PTSR_DEPTH   = 2;

  // Word sequence limits.
  localparam logic [1:0] PTSR_TX_LAST = 2'h3;
  localparam logic [2:0] PTSR_RX_LAST = 3'h5;
  localparam logic [2:0] PTSR_ED_END  = 3'h5;
  localparam logic [2:0] PTSR_ED_TS0  = 3'h1;
  localparam logic [2:0] PTSR_ED_EXT  = 3'h0;

  // Saturation limits.
  localparam logic [1:0] PTSR_OVF_MAX  = 2'h3;
  localparam logic [2:0] PTSR_MISS_MAX = 3'h7;

  // Event status field positions.
  localparam int PTSR_MISS_LSB = 8;
  localparam int PTSR_LEN_LSB  = 6;
  localparam int PTSR_RF_BIT   = 5;
  localparam int PTSR_NUM_LSB  = 2;
  localparam int PTSR_MULT_BIT = 1;
  localparam int PTSR_DET_BIT  = 0;
endpackage

//--- hdl/ptsr_readout.sv
// Timestamp readout: transmit, receive and event queues behind 16-bit reads.
`timescale 1ns/100ps
module ptsr_readout
  import ptsr_pkg::*;
#(
  parameter int UNITS = PTSR_UNITS,
  parameter int DEPTH = PTSR_DEPTH
) (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Management read port.
  input  wire logic                  regRd,
  input  wire logic [4:0]            regAddr,
  output logic [15:0]                regRdData,
  output logic                       regRdValid,
  // Transmit stamp push.
  input  wire logic                  txPushValid,
  input  wire logic [ptsr_pkg::PTSR_NS_W-1:0]  txPushNs,
  input  wire logic [ptsr_pkg::PTSR_SEC_W-1:0] txPushSec,
  output logic                       txPushReady,
  // Receive stamp push.
  input  wire logic                  rxPushValid,
  input  wire logic [ptsr_pkg::PTSR_NS_W-1:0]  rxPushNs,
  input  wire logic [ptsr_pkg::PTSR_SEC_W-1:0] rxPushSec,
  input  wire logic [15:0]           rxPushSeqId,
  input  wire logic [3:0]            rxPushMsgType,
  input  wire logic [11:0]           rxPushHash,
  output logic                       rxPushReady,
  // Event stamp push.
  input  wire logic                  evPushValid,
  input  wire logic [ptsr_pkg::PTSR_NS_W-1:0]  evPushNs,
  input  wire logic [ptsr_pkg::PTSR_SEC_W-1:0] evPushSec,
  input  wire logic [UNITS-1:0]      evPushDet,
  input  wire logic [UNITS-1:0]      evPushRise,
  output logic                       evPushReady
);
  localparam int SW = PTSR_STAMP_W;
  localparam int RW = PTSR_STAMP_W + PTSR_RXID_W;
  localparam int EW = PTSR_STAMP_W + PTSR_EXT_W + PTSR_ESTS_W;

  // Selects one 16-bit word of a stamp, with the overflow count in word 1.
  function automatic logic [15:0] stampWord(input logic [SW-1:0] ts,
                                            input logic [1:0] ovf,
                                            input logic [1:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      2'h0:    w = ts[15:0];
      2'h1:    w = {ovf, ts[29:16]};
      2'h2:    w = ts[45:30];
      2'h3:    w = ts[61:46];
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // Next overflow count; a drop in the clearing cycle still counts.
  function automatic logic [1:0] ovfNext(input logic [1:0] ovf,
                                         input logic clr,
                                         input logic drop);
    logic [1:0] base;
    base = clr ? 2'h0 : ovf;
    if (drop && base != PTSR_OVF_MAX) begin
      base = base + 2'h1;
    end
    return base;
  endfunction

  // Index of the lowest set bit of a unit mask.
  function automatic logic [2:0] lowestIdx(input logic [UNITS-1:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = UNITS - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Address decode.
  wire txRead  = regRd && (regAddr == PTSR_TX_ADDR);
  wire rxRead  = regRd && (regAddr == PTSR_RX_ADDR);
  wire stsRead = regRd && (regAddr == PTSR_ESTS_ADDR);
  wire edRead  = regRd && (regAddr == PTSR_EDAT_ADDR);

  // Transmit queue.
  logic [SW-1:0] txHead;
  logic          txHeadValid;
  logic [1:0]    txWord_q;
  logic [1:0]    txOvf_q;
  wire           txAdv  = txRead && txHeadValid;
  wire           txPop  = txAdv && (txWord_q == PTSR_TX_LAST);
  wire           txDrop = txPushValid && !txPushReady;
  wire           txRpt  = txAdv && (txWord_q == 2'h1);

  ptsr_fifo #(.W(SW), .DEPTH(DEPTH)) txQueue (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   ({txPushSec, txPushNs}),
    .inValid  (txPushValid),
    .inReady  (txPushReady),
    .outData  (txHead),
    .outValid (txHeadValid),
    .outReady (txPop)
  );

  // Receive queue.
  logic [RW-1:0] rxHead;
  logic          rxHeadValid;
  logic [2:0]    rxWord_q;
  logic [1:0]    rxOvf_q;
  wire           rxAdv  = rxRead && rxHeadValid;
  wire           rxPop  = rxAdv && (rxWord_q == PTSR_RX_LAST);
  wire           rxDrop = rxPushValid && !rxPushReady;
  wire           rxRpt  = rxAdv && (rxWord_q == 3'h1);
  wire [15:0]    rxWordData;

  ptsr_fifo #(.W(RW), .DEPTH(DEPTH)) rxQueue (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   ({rxPushMsgType, rxPushHash, rxPushSeqId, rxPushSec, rxPushNs}),
    .inValid  (rxPushValid),
    .inReady  (rxPushReady),
    .outData  (rxHead),
    .outValid (rxHeadValid),
    .outReady (rxPop)
  );

  assign rxWordData = (rxWord_q == 3'h4) ? rxHead[77:62] :
                      (rxWord_q == 3'h5) ? rxHead[93:78] :
                      stampWord(rxHead[SW-1:0], rxOvf_q, rxWord_q[1:0]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txWord_q <= 2'h0;
      txOvf_q  <= 2'h0;
      rxWord_q <= 3'h0;
      rxOvf_q  <= 2'h0;
    end else begin
      if (txAdv) begin
        txWord_q <= txWord_q + 2'h1;
      end
      if (rxAdv) begin
        rxWord_q <= (rxWord_q == PTSR_RX_LAST) ? 3'h0 : rxWord_q + 3'h1;
      end
      txOvf_q <= ovfNext(txOvf_q, txRpt, txDrop);
      rxOvf_q <= ovfNext(rxOvf_q, rxRpt, rxDrop);
    end
  end

  // Per-unit missed-event counters, bumped when the event queue is full.
  logic [2:0]       missCnt_q [UNITS];
  logic [UNITS-1:0] missNz;
  logic [15:0]      extWord;
  wire              evAccept = evPushValid && evPushReady;
  wire              evDrop   = evPushValid && !evPushReady;

  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      assign missNz[gi]        = evPushDet[gi] && (missCnt_q[gi] != 3'h0);
      assign extWord[2*gi]     = evPushDet[gi];
      assign extWord[2*gi + 1] = evPushRise[gi];
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          missCnt_q[gi] <= 3'h0;
        end else if (evDrop && evPushDet[gi] &&
                     missCnt_q[gi] != PTSR_MISS_MAX) begin
          missCnt_q[gi] <= missCnt_q[gi] + 3'h1;
        end else if (evAccept && evPushDet[gi]) begin
          missCnt_q[gi] <= 3'h0;
        end
      end
    end
  endgenerate

  // Status word built at capture time.
  logic [SW-1:0] prevTs_q;
  wire [SW-1:0]  evTs    = {evPushSec, evPushNs};
  wire [SW-1:0]  tsDiff  = evTs ^ prevTs_q;
  wire [2:0]     evSel   = (|missNz) ? lowestIdx(missNz)
                                     : lowestIdx(evPushDet);
  wire           evMult  = |(evPushDet & (evPushDet - 1'b1));
  wire [1:0]     evLen   = (|tsDiff[61:46]) ? 2'h3 :
                           (|tsDiff[45:30]) ? 2'h2 :
                           (|tsDiff[29:16]) ? 2'h1 : 2'h0;
  wire [PTSR_ESTS_W-1:0] evSts;

  assign evSts[PTSR_MISS_LSB +: 3] = missCnt_q[evSel];
  assign evSts[PTSR_LEN_LSB +: 2]  = evLen;
  assign evSts[PTSR_RF_BIT]        = evPushRise[evSel];
  assign evSts[PTSR_NUM_LSB +: 3]  = evSel;
  assign evSts[PTSR_MULT_BIT]      = evMult;
  assign evSts[PTSR_DET_BIT]       = |evPushDet;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevTs_q <= '0;
    end else if (evAccept) begin
      prevTs_q <= evTs;
    end
  end

  // Event queue; the head is taken into the data port on a status read.
  logic [EW-1:0] evHead;
  logic          evHeadValid;
  wire           evPop = stsRead && evHeadValid;

  ptsr_fifo #(.W(EW), .DEPTH(DEPTH)) evQueue (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   ({evSts, extWord, evTs}),
    .inValid  (evPushValid),
    .inReady  (evPushReady),
    .outData  (evHead),
    .outValid (evHeadValid),
    .outReady (evPop)
  );

  wire [PTSR_ESTS_W-1:0] headSts = evHead[EW-1 -: PTSR_ESTS_W];
  logic [SW-1:0]         curTs_q;
  logic [15:0]           curExt_q;
  logic                  curValid_q;
  logic [2:0]            edWord_q;
  wire [1:0]             edIdx = 2'(edWord_q - PTSR_ED_TS0);
  wire [15:0]            edData;

  assign edData = !curValid_q ? PTSR_RESET_WORD :
                  (edWord_q == PTSR_ED_EXT) ? curExt_q :
                  (edWord_q == PTSR_ED_END) ? PTSR_RESET_WORD :
                  stampWord(curTs_q, 2'h0, edIdx);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      curTs_q    <= '0;
      curExt_q   <= 16'h0000;
      curValid_q <= 1'b0;
      edWord_q   <= PTSR_ED_TS0;
    end else if (stsRead) begin
      curValid_q <= evHeadValid;
      curTs_q    <= evHead[SW-1:0];
      curExt_q   <= evHead[SW +: PTSR_EXT_W];
      edWord_q   <= headSts[PTSR_MULT_BIT] ? PTSR_ED_EXT : PTSR_ED_TS0;
    end else if (edRead && edWord_q != PTSR_ED_END) begin
      edWord_q <= edWord_q + 3'h1;
    end
  end

  // Read data selection; status upper bits are tied to zero.
  wire [15:0] stsData = evHeadValid ? {5'h00, headSts}
                                    : PTSR_RESET_WORD;
  wire [15:0] txData  = txHeadValid ? stampWord(txHead, txOvf_q, txWord_q)
                                    : PTSR_RESET_WORD;
  wire [15:0] rxData  = rxHeadValid ? rxWordData : PTSR_RESET_WORD;
  wire [15:0] rdDataD = txRead  ? txData  :
                        rxRead  ? rxData  :
                        stsRead ? stsData :
                        edRead  ? edData  : PTSR_RESET_WORD;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData  <= PTSR_RESET_WORD;
      regRdValid <= 1'b0;
    end else begin
      // Read data stands until the next read so a slow host can still take it.
      if (regRd) begin
        regRdData <= rdDataD;
      end
      regRdValid <= regRd;
    end
  end
endmodule

//--- test/ptsr_host.sv
// Management host model that issues single register reads.
`timescale 1ns/100ps
module ptsr_host (
  // Clock.
  input wire logic        clk_sys,
  // Read port.
  output logic            regRd,
  output logic [4:0]      regAddr,
  input wire logic [15:0] regRdData,
  input wire logic        regRdValid
);
  initial begin
    regRd = 1'b0;
    regAddr = 5'h00;
  end

  // One read; the block sets word order and the caller may stop early.
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk_sys);
    #1;
    regRd = 1'b1;
    regAddr = a;
    @(posedge clk_sys);
    #1;
    regRd = 1'b0;
    // Released address shows a changed value, not the last one.
    regAddr = ~a;
    v = regRdValid;
    d = regRdData;
  endtask
endmodule

//--- test/ptsr_readout_assertions.sv
// Port-level concurrent checks for the timestamp readout block.
`timescale 1ns/100ps
module ptsr_readout_assertions
  import ptsr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        regRd,
  input wire logic [4:0]  regAddr,
  input wire logic [15:0] regRdData,
  input wire logic        regRdValid,
  input wire logic        txPushReady,
  input wire logic        rxPushReady,
  input wire logic        evPushReady
);
  wire rdTx = regRd && regAddr == PTSR_TX_ADDR;
  wire rdRx = regRd && regAddr == PTSR_RX_ADDR;
  wire rdEst = regRd && regAddr == PTSR_ESTS_ADDR;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // A status read followed by its answer cycle.
  sequence s_est_answer;
    rdEst ##1 regRdValid;
  endsequence

  a_read_answer: assert property (regRd |=> regRdValid)
    else $error("read not answered one cycle later");
  a_idle_quiet: assert property (!regRd |=> !regRdValid && $stable(regRdData))
    else $error("read port changed without a read");
  a_status_upper: assert property (s_est_answer |-> regRdData[15:11] == 5'h00)
    else $error("status upper bits not zero");
  a_status_empty: assert property
    (s_est_answer |-> regRdData[0] || regRdData == 16'h0000)
    else $error("status fields set without detection");
  a_mult_det: assert property (s_est_answer |-> !regRdData[1] || regRdData[0])
    else $error("multiple flag without detection");
  a_tx_full_hold: assert property
    (!txPushReady && !rdTx && !$past(rdTx) |=> !txPushReady)
    else $error("transmit queue freed without a read");
  a_rx_full_hold: assert property
    (!rxPushReady && !rdRx && !$past(rdRx) |=> !rxPushReady)
    else $error("receive queue freed without a read");
  a_ev_full_hold: assert property
    (!evPushReady && !rdEst && !$past(rdEst) |=> !evPushReady)
    else $error("event queue advanced without a status read");
endmodule

//--- test/ptsr_readout_tb_top.sv
// Self-checking bench for the timestamp readout block.
`timescale 1ns/100ps
module ptsr_readout_tb_top;
  import ptsr_pkg::*;
  logic        clk_sys, rst, regRd, regRdValid;
  logic [4:0]  regAddr;
  logic [15:0] regRdData, rxPushSeqId;
  logic        txPushValid, txPushReady, rxPushValid, rxPushReady;
  logic        evPushValid, evPushReady;
  logic [29:0] txPushNs, rxPushNs, evPushNs;
  logic [31:0] txPushSec, rxPushSec, evPushSec;
  logic [3:0]  rxPushMsgType;
  logic [11:0] rxPushHash;
  logic [7:0]  evPushDet, evPushRise;
  int          badCount, samplesChecked;

  ptsr_readout u_ptsr_readout (.clk_sys, .rst, .regRd, .regAddr,
    .regRdData, .regRdValid, .txPushValid, .txPushNs, .txPushSec,
    .txPushReady, .rxPushValid, .rxPushNs, .rxPushSec, .rxPushSeqId,
    .rxPushMsgType, .rxPushHash, .rxPushReady, .evPushValid, .evPushNs,
    .evPushSec, .evPushDet, .evPushRise, .evPushReady);
  ptsr_host u_ptsr_host (.clk_sys, .regRd, .regAddr, .regRdData,
    .regRdValid);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic giveVerdict();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    cmp16({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    u_ptsr_host.rd(a, d, v);
    cmp1(v, 1'b1);
    cmp16(d, e);
  endtask

  task automatic rdn(input logic [4:0] a, input int n,
                     input logic [15:0] w [6]);
    for (int i = 0; i < n; i++) begin
      rdc(a, w[i]);
    end
  endtask

  // Offers one entry; a count above one holds it that many cycles, refused or not.
  task automatic ptx(input logic [29:0] ns, input logic [31:0] s,
                     input int n);
    @(posedge clk_sys);
    #1;
    txPushValid = 1'b1;
    txPushNs = ns;
    txPushSec = s;
    repeat (n) @(posedge clk_sys);
    #1;
    txPushValid = 1'b0;
  endtask

  task automatic pev(input logic [29:0] ns, input logic [31:0] s,
                     input logic [7:0] det, input logic [7:0] rise,
                     input int n);
    @(posedge clk_sys);
    #1;
    evPushValid = 1'b1;
    evPushNs = ns;
    evPushSec = s;
    evPushDet = det;
    evPushRise = rise;
    repeat (n) @(posedge clk_sys);
    #1;
    evPushValid = 1'b0;
  endtask

  task automatic t_reset();
    cmp1(txPushReady & rxPushReady & evPushReady, 1'b1);
    rdc(PTSR_TX_ADDR, 16'h0000);
    rdc(5'h00, 16'h0000);
  endtask

  task automatic t_tx();
    ptx(30'h1ABCDEF0, 32'h89ABCDEF, 1);
    ptx(30'h00000001, 32'h00000002, 1);
    cmp1(txPushReady, 1'b0);
    ptx(30'h00000003, 32'h00000004, 5);
    rdn(PTSR_TX_ADDR, 4, '{16'hDEF0, 16'hDABC, 16'hCDEF, 16'h89AB,
        16'h0000, 16'h0000});
    rdn(PTSR_TX_ADDR, 4, '{16'h0001, 16'h0000, 16'h0002, 16'h0000,
        16'h0000, 16'h0000});
    cmp1(txPushReady, 1'b1);
    rdc(PTSR_TX_ADDR, 16'h0000);
  endtask

  task automatic t_rx();
    @(posedge clk_sys);
    #1;
    rxPushValid = 1'b1;
    rxPushNs = 30'h3FFFFFFF;
    rxPushSec = 32'hFFFF0000;
    rxPushSeqId = 16'hBEEF;
    rxPushMsgType = 4'hA;
    rxPushHash = 12'h123;
    @(posedge clk_sys);
    #1;
    rxPushValid = 1'b0;
    rdn(PTSR_RX_ADDR, 6, '{16'hFFFF, 16'h3FFF, 16'h0000, 16'hFFFF,
        16'hBEEF, 16'hA123});
    rdc(PTSR_RX_ADDR, 16'h0000);
  endtask

  task automatic t_event();
    pev(30'h00001234, 32'h00010000, 8'h08, 8'h08, 1);
    pev(30'h00005678, 32'h00010000, 8'h22, 8'h20, 1);
    rdc(PTSR_ESTS_ADDR, 16'h00ED);
    rdn(PTSR_EDAT_ADDR, 4, '{16'h1234, 16'h0000, 16'h0000, 16'h0001,
        16'h0000, 16'h0000});
    rdc(PTSR_ESTS_ADDR, 16'h0007);
    rdn(PTSR_EDAT_ADDR, 2, '{16'h0C04, 16'h5678, 16'h0000, 16'h0000,
        16'h0000, 16'h0000});
    rdc(PTSR_ESTS_ADDR, 16'h0000);
    rdc(PTSR_EDAT_ADDR, 16'h0000);
  endtask

  task automatic t_missed();
    pev(30'h00005678, 32'h00010000, 8'h01, 8'h00, 1);
    pev(30'h00005678, 32'h00010000, 8'h01, 8'h00, 1);
    cmp1(evPushReady, 1'b0);
    pev(30'h00000009, 32'h00000009, 8'h40, 8'h40, 8);
    rdc(PTSR_ESTS_ADDR, 16'h0001);
    rdc(PTSR_ESTS_ADDR, 16'h0001);
    pev(30'h20005678, 32'h00010000, 8'h50, 8'h40, 1);
    rdc(PTSR_ESTS_ADDR, 16'h077B);
    pev(30'h20005678, 32'h00010000, 8'h40, 8'h00, 1);
    rdc(PTSR_ESTS_ADDR, 16'h0019);
  endtask

  initial begin
    {rst, txPushValid, rxPushValid, evPushValid} = 4'h8;
    {txPushNs, txPushSec, rxPushNs, rxPushSec} = '0;
    {rxPushSeqId, rxPushMsgType, rxPushHash} = '0;
    {evPushNs, evPushSec, evPushDet, evPushRise} = '0;
    badCount = 0;
    samplesChecked = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_event();
    t_missed();
    giveVerdict();
  end

  // Cuts a hang short and reports it as a mismatch.
  initial begin
    #200000;
    badCount++;
    giveVerdict();
  end
endmodule

bind ptsr_readout ptsr_readout_assertions u_ptsr_readout_assertions (
  .clk_sys, .rst, .regRd, .regAddr, .regRdData, .regRdValid,
  .txPushReady, .rxPushReady, .evPushReady);
